// ==== common/p1pf_pkg.sv ====
// Purpose: constants for the port 1 pin function and pull-up block
// Assumes: registers reached over AXI4-Lite, 32-bit data, one word each
// Notes: register offsets are byte addresses
// Operation
// - select bit picks alternate, else direction decides
// - hi-z in reset/standby, hold in sleep/watch
// - standby pin with pull-up on reads high
// - pull-up on only when input and enabled
// - pull-ups disabled after reset
// - function select register, reset zero, bit4 zero
// - pull-up control register clears on reset
package p1pf_pkg;
	localparam int unsigned PW = 8;
	localparam logic [3:0] OFF_DIR = 4'h0;
	localparam logic [3:0] OFF_PUP = 4'h4;
	localparam logic [3:0] OFF_FSEL = 4'h8;
	localparam logic [3:0] OFF_DOUT = 4'hc;
	localparam logic [3:0] OFF_PIN = 4'h0;
	localparam logic [3:0] OFF_MODE = 4'h4;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_PUP = 8'h00;
	localparam logic [7:0] RST_FSEL = 8'h00;
	localparam logic [7:0] RST_DOUT = 8'h00;
	// writable bits of the function select register, bit 4 reserved
	localparam logic [7:0] FSEL_MASK = 8'hef;
	// pins that carry an alternate function
	localparam logic [7:0] ALT_PINS = 8'hef;
	// pins whose alternate function drives the pin
	localparam logic [7:0] ALT_OUT_PINS = 8'h07;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		P1PF_ACTIVE = 3'h0,
		P1PF_SUBACTIVE = 3'h1,
		P1PF_SLEEP = 3'h2,
		P1PF_SUBSLEEP = 3'h3,
		P1PF_WATCH = 3'h4,
		P1PF_STANDBY = 3'h5
	} p1pf_mode_e;
endpackage

// ==== rtl/p1pf_pin.sv ====
`timescale 1ns/10ps
// Purpose: drive state of one port pin
// Assumes: control inputs registered by the caller, alternate peripheral inputs passed in unregistered
// Notes: combinational helper, caller registers outputs
module p1pf_pin (
	// selection
	input wire logic i_alt_sel,
	input wire logic i_alt_drives,
	input wire logic i_dir,
	input wire logic i_pup,
	// sources
	input wire logic i_alt_oe,
	input wire logic i_alt_out,
	input wire logic i_dout,
	// results
	output logic o_oe,
	output logic o_out,
	output logic o_pup_on
);
	// function select steers buffer, direction only when unselected
	always_comb begin
		if (i_alt_sel) begin
			o_oe = i_alt_drives & i_alt_oe;
			o_out = i_alt_out;
		end else begin
			o_oe = i_dir;
			o_out = i_dout;
		end
		// pull-up only on an input with its control bit set
		o_pup_on = ~o_oe & ~i_dir & i_pup;
	end
endmodule

// ==== rtl/p1pf_top.sv ====
`timescale 1ns/10ps
// Purpose: port 1 pin function, direction and pull-up control
// Assumes: synchronous pin inputs, one clock, AXI4-Lite slave
// Notes: output state held while the chip sleeps
module p1pf_top (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// operating mode
	input wire logic [2:0] i_mode,
	// alternate peripherals
	input wire logic [7:0] i_alt_oe,
	input wire logic [7:0] i_alt_out,
	// pins
	input wire logic [7:0] i_pin,
	output logic [7:0] o_pin,
	output logic [7:0] o_pin_oe,
	output logic [7:0] o_pullup_on,
	// input to peripherals and routing
	output logic [7:0] o_pin_in,
	output logic [7:0] o_alt_sel,
	// axi write address
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [3:0] i_awaddr,
	// axi write data
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// axi write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// axi read address
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [3:0] i_araddr,
	// axi read data
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);
	typedef struct packed {
		logic [7:0] dir; // direction register
		logic [7:0] pup; // pull-up control register
		logic [7:0] fsel; // function select register
		logic [7:0] dout; // output data
		logic [7:0] pin_o;
		logic [7:0] pin_oe;
		logic [7:0] pup_on;
		logic [7:0] pin_in;
		logic aw_got;
		logic [3:0] aw_addr;
		logic w_got;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} p1pf_state_s;

	logic [1:0] rst_sync_r; // reset release chain
	logic nrst; // released reset
	p1pf_state_s st_r;
	p1pf_state_s st_nxt;
	logic [7:0] calc_oe; // per-pin enable
	logic [7:0] calc_out; // per-pin value
	logic [7:0] calc_pup; // per-pin pull-up

	// two-flop release of the asynchronous reset
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign nrst = rst_sync_r[1];

	// per-pin mux; pin 4 never has an alternate function
	for (genvar g = 0; g < p1pf_pkg::PW; g++) begin : g_pin
		p1pf_pin u_pin (
			.i_alt_sel(st_r.fsel[g] & p1pf_pkg::ALT_PINS[g]),
			.i_alt_drives(p1pf_pkg::ALT_OUT_PINS[g]),
			.i_dir(st_r.dir[g]),
			.i_pup(st_r.pup[g]),
			.i_alt_oe(i_alt_oe[g]),
			.i_alt_out(i_alt_out[g]),
			.i_dout(st_r.dout[g]),
			.o_oe(calc_oe[g]),
			.o_out(calc_out[g]),
			.o_pup_on(calc_pup[g])
		);
	end

	// next state: bus slave and pin state per operating mode
	always_comb begin
		st_nxt = st_r;
		// pin drive depends on operating mode
		case (p1pf_pkg::p1pf_mode_e'(i_mode))
			p1pf_pkg::P1PF_ACTIVE, p1pf_pkg::P1PF_SUBACTIVE: begin
				st_nxt.pin_oe = calc_oe;
				st_nxt.pin_o = calc_out;
				st_nxt.pup_on = calc_pup;
				st_nxt.pin_in = i_pin;
			end
			p1pf_pkg::P1PF_SLEEP, p1pf_pkg::P1PF_SUBSLEEP, p1pf_pkg::P1PF_WATCH: begin
				// keep every pin output as it was
				st_nxt.pin_oe = st_r.pin_oe; // hold previous pin state
			end
			p1pf_pkg::P1PF_STANDBY: begin
				// pull-up pins still show high, all others float
				st_nxt.pin_oe = 8'h00;
				st_nxt.pin_o = 8'h00;
				st_nxt.pup_on = calc_pup;
			end
			default: begin
				st_nxt.pin_oe = 8'h00;
				st_nxt.pin_o = 8'h00;
				st_nxt.pup_on = 8'h00;
			end
		endcase
		// capture write address and data in either order
		if (i_awvalid && !st_r.aw_got) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = i_awaddr;
		end
		if (i_wvalid && !st_r.w_got) begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_data = i_wdata[7:0];
			st_nxt.w_lane0 = i_wstrb[0];
		end
		// perform write once both halves held and response free
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = p1pf_pkg::RESP_OKAY;
			case (st_r.aw_addr)
				p1pf_pkg::OFF_DIR: begin
					if (st_r.w_lane0) st_nxt.dir = st_r.w_data;
				end
				p1pf_pkg::OFF_PUP: begin
					if (st_r.w_lane0) st_nxt.pup = st_r.w_data;
				end
				p1pf_pkg::OFF_FSEL: begin
					// reserved bit kept at zero
					if (st_r.w_lane0) st_nxt.fsel = st_r.w_data & p1pf_pkg::FSEL_MASK;
				end
				p1pf_pkg::OFF_DOUT: begin
					if (st_r.w_lane0) st_nxt.dout = st_r.w_data;
				end
				default: begin
					st_nxt.bresp = p1pf_pkg::RESP_SLVERR;
				end
			endcase
		end
		// write response handshake
		if (st_r.bvalid && i_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// read: accept address when no data pending
		if (i_arvalid && !st_r.rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = p1pf_pkg::RESP_OKAY;
			case (i_araddr)
				p1pf_pkg::OFF_DIR: st_nxt.rdata = {24'h000000, st_r.dir};
				p1pf_pkg::OFF_PUP: st_nxt.rdata = {24'h000000, st_r.pup};
				p1pf_pkg::OFF_FSEL: st_nxt.rdata = {24'h000000, st_r.fsel};
				p1pf_pkg::OFF_DOUT: st_nxt.rdata = {24'h000000, st_r.dout};
				// pin levels beyond the 4-bit address space are not readable
				default: begin
					st_nxt.rdata = 32'h00000000;
					st_nxt.rresp = p1pf_pkg::RESP_SLVERR;
				end
			endcase
		end else if (st_r.rvalid && i_rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	// state register; reset floats every pin and clears control
	always_ff @(posedge i_clock or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.dir <= p1pf_pkg::RST_DIR;
			st_r.pup <= p1pf_pkg::RST_PUP;
			st_r.fsel <= p1pf_pkg::RST_FSEL;
			st_r.dout <= p1pf_pkg::RST_DOUT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign o_pin = st_r.pin_o;
	assign o_pin_oe = st_r.pin_oe;
	assign o_pullup_on = st_r.pup_on;
	assign o_pin_in = st_r.pin_in;
	assign o_alt_sel = st_r.fsel & p1pf_pkg::ALT_PINS;
	assign o_awready = ~st_r.aw_got;
	assign o_wready = ~st_r.w_got;
	assign o_bvalid = st_r.bvalid;
	assign o_bresp = st_r.bresp;
	assign o_arready = ~st_r.rvalid;
	assign o_rvalid = st_r.rvalid;
	assign o_rdata = st_r.rdata;
	assign o_rresp = st_r.rresp;
endmodule

// ==== verification/p1pf_board.sv ====
`timescale 1ns/10ps
// Purpose: board circuit on the port pins
// Assumes: pull-up holds a released pin high
// Notes: an open pin toggles each cycle
module p1pf_board (
	input wire logic i_clock,
	input wire logic [7:0] i_oe,
	input wire logic [7:0] i_out,
	input wire logic [7:0] i_pu,
	output logic [7:0] o_level
);
	logic [7:0] flt_r = 8'h00; // open pin stand-in
	always_ff @(posedge i_clock) flt_r <= ~flt_r;
	// block drive, else pull-up, else floating
	assign o_level = (i_oe & i_out) | (~i_oe & (i_pu | flt_r));
endmodule

// ==== verification/p1pf_checker.sv ====
`timescale 1ns/10ps
// Purpose: port-level checks of the port 1 block
// Assumes: bound to p1pf_top, one clock
// Notes: pin outputs lag their cause by a cycle
module p1pf_checker (
	// clock, reset, mode
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [2:0] i_mode,
	// pins and routing
	input wire logic [7:0] i_alt_oe,
	input wire logic [7:0] o_pin,
	input wire logic [7:0] o_pin_oe,
	input wire logic [7:0] o_pullup_on,
	input wire logic [7:0] o_alt_sel,
	// bus write
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// three settled active cycles
	sequence s_calm;
		(i_mode == 3'h0 && $stable(i_alt_oe) && $stable(o_alt_sel))[*3];
	endsequence
	// address and data taken together
	sequence s_wr;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	property p_pu; (o_pullup_on & o_pin_oe) == 8'h00; endproperty
	a_pu: assert property (p_pu) else $error("pull-up on driven pin");
	property p_alt; s_calm |-> ((o_pin_oe ^ i_alt_oe) & o_alt_sel & 8'h07) == 8'h00; endproperty
	a_alt: assert property (p_alt) else $error("peripheral enable not routed");
	property p_ain; s_calm |-> (o_alt_sel & 8'he8 & o_pin_oe) == 8'h00; endproperty
	a_ain: assert property (p_ain) else $error("selected input driven");
	property p_b4; o_alt_sel[4] == 1'h0; endproperty
	a_b4: assert property (p_b4) else $error("reserved select set");
	property p_sb; (i_mode == 3'h5)[*3] |-> o_pin_oe == 8'h00; endproperty
	a_sb: assert property (p_sb) else $error("pin driven in standby");
	property p_hold; (i_mode inside {3'h2, 3'h3, 3'h4})[*3] |-> $stable(o_pin_oe) && $stable(o_pin);
	endproperty
	a_hold: assert property (p_hold) else $error("pin changed while held");
	property p_rst; $rose(i_nrst) |-> o_pin_oe == 8'h00 && o_pullup_on == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("pin active after reset");
	property p_wr; s_wr |-> ##[1:2] o_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
endmodule
bind p1pf_top p1pf_checker p1pf_checker_i (.*);

// ==== verification/port1_pin_function_pullup_tb.sv ====
`timescale 1ns/10ps
// Purpose: self-checking bench of the port 1 block
// Assumes: board model on the pins
// Notes: inputs change at rising edges
module port1_pin_function_pullup_tb;
	logic i_clock = 1'h0, i_nrst = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0;
	logic i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
	logic [2:0] i_mode = 3'h0;
	logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
	logic [7:0] i_alt_oe = 8'h00, i_alt_out = 8'h00, i_pin, o_pin, o_pin_oe;
	logic [7:0] o_pullup_on, o_pin_in, o_alt_sel;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	int n_fail = 0, compares = 0, cyc = 0;
	always #50 i_clock = ~i_clock;
	p1pf_top p1pf_top_i (.*);
	p1pf_board p1pf_board_i (.i_clock(i_clock), .i_oe(o_pin_oe), .i_out(o_pin),
		.i_pu(o_pullup_on), .o_level(i_pin));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	// bus write, held until each channel is taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_awaddr <= a;
		i_wdata <= {24'h0, d};
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'h0;
			if (o_wready) i_wvalid <= 1'h0;
		end while (!o_bvalid);
		i_bready <= 1'h0;
		chk("bresp", (a[1:0] == 2'h0) ? 32'h0 : 32'h2, {30'h0, o_bresp});
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clock);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'h0;
		end while (!o_rvalid);
		i_rready <= 1'h0;
		chk("rdata", {24'h0, e}, o_rdata);
		chk("rresp", (a[1:0] == 2'h0) ? 32'h0 : 32'h2, {30'h0, o_rresp});
	endtask
	task automatic t_rst;
		rd(4'h0, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h8, 8'h00);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h00);
		rd(4'h0, 8'h00);
		chk("pullup", 8'h00, o_pullup_on);
		$display("reset test done");
	endtask
	// pins 4..0 out, all pull-ups asked for
	task automatic t_dir;
		wr(4'h0, 8'h1f);
		wr(4'hc, 8'h12);
		wr(4'h4, 8'hff);
		w(3);
		chk("oe", 8'h1f, o_pin_oe);
		chk("pin", 8'h12, o_pin & 8'h1f);
		chk("pullup", 8'he0, o_pullup_on);
		chk("pin_in", 8'he0, o_pin_in & 8'he0);
		$display("direction test done");
	endtask
	task automatic t_alt;
		i_alt_oe <= 8'hfd;
		i_alt_out <= 8'h05;
		wr(4'h8, 8'hff);
		rd(4'h8, 8'hef);
		w(3);
		chk("alt_sel", 8'hef, o_alt_sel);
		chk("oe", 8'h15, o_pin_oe);
		chk("pin", 8'h05, o_pin & 8'h05);
		chk("pullup", 8'he0, o_pullup_on);
		$display("alternate test done");
	endtask
	task automatic t_mode;
		i_mode <= 3'h2;
		wr(4'h8, 8'h00);
		wr(4'hc, 8'h00);
		w(3);
		chk("oe", 8'h15, o_pin_oe);
		i_mode <= 3'h5;
		w(4);
		chk("oe", 8'h00, o_pin_oe);
		chk("pin", 8'he0, i_pin & 8'he0);
		i_mode <= 3'h0;
		w(4);
		chk("oe", 8'h1f, o_pin_oe);
		chk("pin", 8'h00, o_pin & 8'h1f);
		i_nrst <= 1'h0;
		w(2);
		chk("oe", 8'h00, o_pin_oe);
		i_nrst <= 1'h1;
		w(3);
		rd(4'h4, 8'h00);
		$display("mode test done");
	endtask
	task automatic summarize;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		w(8);
		chk("oe", 8'h00, o_pin_oe);
		i_nrst <= 1'h1;
		w(3);
		t_rst();
		t_dir();
		t_alt();
		t_mode();
		summarize();
	end
endmodule
